// ==== half_bridge_pkg.sv ====
// ============================================================
// Shared constants of the half-bridge serial control port
package half_bridge_pkg;

    // ============================================================
    // Word layout
    localparam int WORD_BITS = 16;
    localparam int CNT_BITS = 4;
    localparam int DRV_COUNT = 12;
    localparam int DRV_LSB = 1;
    localparam int OV_EN_BIT = 15;
    localparam int UL_EN_BIT = 14;
    localparam int OC_EN_BIT = 13;
    localparam int CLR_BIT = 0;
    localparam int SUPPLY_FAIL_BIT = 15;
    localparam int UNDERLOAD_BIT = 14;
    localparam int OVERLOAD_BIT = 13;
    localparam int THERMAL_BIT = 0;

    // ============================================================
    // Reset values
    localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
    localparam logic [DRV_COUNT-1:0] DRV_RESET = 12'h000;
    localparam logic [CNT_BITS-1:0] CNT_RESET = 4'h0;
    localparam logic [CNT_BITS-1:0] CNT_ONE = 4'h1;

    // ============================================================
    // Pin synchroniser vector
    localparam int PIN_BITS = 4;
    localparam int PIN_SEL = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_EN = 3;
    localparam logic [PIN_BITS-1:0] PIN_RESET = 4'h1;

    // ============================================================
    // Fault input vector
    localparam int FAULT_BITS = 28;
    localparam int FLT_OV = 0;
    localparam int FLT_UV = 1;
    localparam int FLT_OT = 2;
    localparam int FLT_TW = 3;
    localparam int FLT_UL_LSB = 4;
    localparam int FLT_OC_LSB = 16;
    localparam logic [FAULT_BITS-1:0] FAULT_RESET = 28'h0000000;

    // ============================================================
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SEL_HIGH_MIN_NS = 200;
    localparam int SEL_HIGH_MIN_CYC = (SEL_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CNT_BITS = 6;
    localparam logic [GAP_CNT_BITS-1:0] GAP_MIN = GAP_CNT_BITS'(SEL_HIGH_MIN_CYC);
    localparam logic [GAP_CNT_BITS-1:0] GAP_RESET = 6'h00;
    localparam logic [GAP_CNT_BITS-1:0] GAP_ONE = 6'h01;

    // ============================================================
    // Frame state
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SHIFT = 1'b1
    } frame_state_type;

endpackage

// ==== half_bridge_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Three-stage synchroniser; a change counts once stages two and three agree
module half_bridge_pin_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] raw_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] agree;

    assign agree = stage2_reg ~^ stage3_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            stage1_reg <= RESET_VAL;
            stage2_reg <= RESET_VAL;
            stage3_reg <= RESET_VAL;
        end
        else
        begin
            stage1_reg <= raw_i;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            sync_reg <= RESET_VAL;
        else
            sync_reg <= (agree & stage2_reg) | (~agree & sync_reg);
    end

    assign sync_o = sync_reg;

endmodule
`default_nettype wire

// ==== half_bridge_spi_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module half_bridge_spi_port (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic enable_i,
    input wire logic select_low_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    input wire logic overvoltage_i,
    input wire logic undervoltage_lockout_i,
    input wire logic over_temp_i,
    input wire logic thermal_warning_i,
    input wire logic [half_bridge_pkg::DRV_COUNT-1:0] underload_i,
    input wire logic [half_bridge_pkg::DRV_COUNT-1:0] overcurrent_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic [half_bridge_pkg::DRV_COUNT-1:0] drive_o,
    output logic overvoltage_shutdown_enable_o,
    output logic underload_shutdown_enable_o,
    output logic overcurrent_shutdown_enable_o,
    output logic frame_accept_o,
    output logic frame_reject_o,
    output logic select_gap_short_o
);
    import half_bridge_pkg::*;

    // ============================================================
    // Input synchronisation
    logic [PIN_BITS-1:0] pin_raw;
    logic [PIN_BITS-1:0] pin_sync;
    logic [FAULT_BITS-1:0] fault_raw;
    logic [FAULT_BITS-1:0] fault_sync;

    assign pin_raw = {enable_i, sdi_i, sclk_i, select_low_i};
    assign fault_raw = {overcurrent_i, underload_i, thermal_warning_i,
                        over_temp_i, undervoltage_lockout_i, overvoltage_i};

    half_bridge_pin_sync #(
        .WIDTH(PIN_BITS),
        .RESET_VAL(PIN_RESET)
    ) pin_sync_inst (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .raw_i(pin_raw),
        .sync_o(pin_sync)
    );

    half_bridge_pin_sync #(
        .WIDTH(FAULT_BITS),
        .RESET_VAL(FAULT_RESET)
    ) fault_sync_inst (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .raw_i(fault_raw),
        .sync_o(fault_sync)
    );

    // ============================================================
    // Edge detection and sleep
    logic sel_prev_reg;
    logic sclk_prev_reg;
    logic sel_fall;
    logic sel_rise;
    logic sclk_fall;
    logic sclk_rise;
    logic sleep;
    logic clear_all;

    assign sleep = ~pin_sync[PIN_EN];
    assign clear_all = sys_rst_i | sleep;
    assign sel_fall = sel_prev_reg & ~pin_sync[PIN_SEL];
    assign sel_rise = ~sel_prev_reg & pin_sync[PIN_SEL];
    assign sclk_fall = sclk_prev_reg & ~pin_sync[PIN_SCLK];
    assign sclk_rise = ~sclk_prev_reg & pin_sync[PIN_SCLK];

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            sel_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            sel_prev_reg <= pin_sync[PIN_SEL];
            sclk_prev_reg <= pin_sync[PIN_SCLK];
        end
    end

    // ============================================================
    // Frame state
    frame_state_type state_reg;
    frame_state_type state_next;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (sel_fall)
                    state_next = ST_SHIFT;
            end
            ST_SHIFT:
            begin
                if (sel_rise)
                    state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // ============================================================
    // Bit counting
    logic [CNT_BITS-1:0] bit_cnt_reg;
    logic got_bit_reg;
    logic rx_bit_reg;
    logic shifting;

    assign shifting = (state_reg == ST_SHIFT) && !sel_rise;

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all || sel_fall)
        begin
            bit_cnt_reg <= CNT_RESET;
            got_bit_reg <= 1'b0;
        end
        else if (shifting && sclk_fall)
        begin
            bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
            got_bit_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all)
            rx_bit_reg <= 1'b0;
        else if (shifting && sclk_fall)
            rx_bit_reg <= pin_sync[PIN_SDI];
    end

    // ============================================================
    // Shift register, status out and command in
    logic [WORD_BITS-1:0] shift_reg;
    logic [WORD_BITS-1:0] status_word;
    logic [WORD_BITS-1:0] rx_word;
    logic frame_ok;
    logic frame_bad;

    assign rx_word = {rx_bit_reg, shift_reg[WORD_BITS-1:1]};
    assign frame_ok = (state_reg == ST_SHIFT) && sel_rise
                      && got_bit_reg && (bit_cnt_reg == CNT_RESET);
    assign frame_bad = (state_reg == ST_SHIFT) && sel_rise && !frame_ok;

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all)
            shift_reg <= WORD_RESET;
        else if (sel_fall)
            shift_reg <= status_word;
        else if (shifting && sclk_rise && got_bit_reg)
            shift_reg <= {rx_bit_reg, shift_reg[WORD_BITS-1:1]};
    end

    logic sdo_oe_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all)
            sdo_oe_reg <= 1'b0;
        else
            sdo_oe_reg <= (state_next == ST_SHIFT);
    end

    assign sdo_o = shift_reg[0];
    assign sdo_oe_o = sdo_oe_reg;

    // ============================================================
    // Control registers
    logic [DRV_COUNT-1:0] drv_cmd_reg;
    logic ov_en_reg;
    logic ul_en_reg;
    logic oc_en_reg;
    logic clr_req;

    assign clr_req = frame_ok && rx_word[CLR_BIT];

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all)
        begin
            drv_cmd_reg <= DRV_RESET;
            ov_en_reg <= 1'b0;
            ul_en_reg <= 1'b0;
            oc_en_reg <= 1'b0;
        end
        else if (frame_ok)
        begin
            drv_cmd_reg <= rx_word[DRV_LSB +: DRV_COUNT];
            ov_en_reg <= rx_word[OV_EN_BIT];
            ul_en_reg <= rx_word[UL_EN_BIT];
            oc_en_reg <= rx_word[OC_EN_BIT];
        end
    end

    assign overvoltage_shutdown_enable_o = ov_en_reg;
    assign underload_shutdown_enable_o = ul_en_reg;
    assign overcurrent_shutdown_enable_o = oc_en_reg;

    // ============================================================
    // Fault events
    logic [DRV_COUNT-1:0] ul_hit;
    logic [DRV_COUNT-1:0] oc_hit;
    logic supply_event;
    logic global_off;

    assign ul_hit = fault_sync[FLT_UL_LSB +: DRV_COUNT] & drive_o;
    assign oc_hit = fault_sync[FLT_OC_LSB +: DRV_COUNT] & drive_o;
    assign supply_event = fault_sync[FLT_OV] | fault_sync[FLT_UV];
    assign global_off = (fault_sync[FLT_OV] & ov_en_reg)
                        | fault_sync[FLT_UV] | fault_sync[FLT_OT];

    // ============================================================
    // Sticky status flags, set wins over clear
    logic supply_fail_flag_reg;
    logic underload_flag_reg;
    logic overload_flag_reg;
    logic thermal_warning_flag_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all)
            supply_fail_flag_reg <= 1'b0;
        else
            supply_fail_flag_reg <= (supply_fail_flag_reg & ~clr_req) | supply_event;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all)
            underload_flag_reg <= 1'b0;
        else
            underload_flag_reg <= (underload_flag_reg & ~clr_req) | (|ul_hit);
    end

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all)
            overload_flag_reg <= 1'b0;
        else
            overload_flag_reg <= (overload_flag_reg & ~clr_req) | (|oc_hit);
    end

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all)
            thermal_warning_flag_reg <= 1'b0;
        else
            thermal_warning_flag_reg <= (thermal_warning_flag_reg & ~clr_req)
                                        | fault_sync[FLT_TW];
    end

    // ============================================================
    // Per-driver latch-off and driver outputs
    logic [DRV_COUNT-1:0] latch_off_reg;
    logic [DRV_COUNT-1:0] drive_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all)
            latch_off_reg <= DRV_RESET;
        else
            latch_off_reg <= (latch_off_reg & ~{DRV_COUNT{clr_req}})
                             | (ul_hit & {DRV_COUNT{ul_en_reg}})
                             | (oc_hit & {DRV_COUNT{oc_en_reg}});
    end

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all)
            drive_reg <= DRV_RESET;
        else
            drive_reg <= drv_cmd_reg & ~latch_off_reg & ~{DRV_COUNT{global_off}};
    end

    assign drive_o = drive_reg;

    assign status_word = {supply_fail_flag_reg, underload_flag_reg, overload_flag_reg,
                          drive_reg, thermal_warning_flag_reg};

    // ============================================================
    // Frame result pulses
    logic frame_accept_reg;
    logic frame_reject_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all)
        begin
            frame_accept_reg <= 1'b0;
            frame_reject_reg <= 1'b0;
        end
        else
        begin
            frame_accept_reg <= frame_ok;
            frame_reject_reg <= frame_bad;
        end
    end

    assign frame_accept_o = frame_accept_reg;
    assign frame_reject_o = frame_reject_reg;

    // ============================================================
    // Select high time monitor
    logic [GAP_CNT_BITS-1:0] gap_cnt_reg;
    logic gap_short_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all || !pin_sync[PIN_SEL])
            gap_cnt_reg <= GAP_RESET;
        else if (gap_cnt_reg != GAP_MIN)
            gap_cnt_reg <= gap_cnt_reg + GAP_ONE;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (clear_all)
            gap_short_reg <= 1'b0;
        else if (sel_fall)
            gap_short_reg <= (gap_cnt_reg != GAP_MIN);
    end

    assign select_gap_short_o = gap_short_reg;

endmodule
`default_nettype wire

// ==== half_bridge_spi_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port-level checks of the serial control port
module half_bridge_spi_checker (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic enable_i,
    input wire logic select_low_i,
    input wire logic overvoltage_i,
    input wire logic undervoltage_lockout_i,
    input wire logic over_temp_i,
    input wire logic [half_bridge_pkg::DRV_COUNT-1:0] underload_i,
    input wire logic [half_bridge_pkg::DRV_COUNT-1:0] overcurrent_i,
    input wire logic sdo_oe_o,
    input wire logic [half_bridge_pkg::DRV_COUNT-1:0] drive_o,
    input wire logic overvoltage_shutdown_enable_o,
    input wire logic underload_shutdown_enable_o,
    input wire logic overcurrent_shutdown_enable_o,
    input wire logic frame_accept_o,
    input wire logic frame_reject_o
);
    import half_bridge_pkg::*;
    logic [3:0] quiet_cnt;
    logic quiet;
    logic flt_any;
    assign flt_any = overvoltage_i | undervoltage_lockout_i | over_temp_i | (|underload_i) | (|overcurrent_i);
    assign quiet = quiet_cnt == 4'hf;
    // ============================================================
    // Cycles since any fault input other than the thermal warning, or sleep, was last seen
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i || !enable_i || flt_any)
            quiet_cnt <= 4'h0;
        else if (!quiet)
            quiet_cnt <= quiet_cnt + 4'h1;
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // ============================================================
    // Assertions
    oe_idle_a: assert property (select_low_i [*8] |-> !sdo_oe_o)
        else $error("serial output enabled while deselected");
    oe_active_a: assert property ((!select_low_i && enable_i) [*8] |-> sdo_oe_o)
        else $error("serial output not enabled during frame");
    pulse_excl_a: assert property (!(frame_accept_o && frame_reject_o))
        else $error("frame both accepted and rejected");
    pulse_after_rise_a: assert property ((frame_accept_o || frame_reject_o) |->
        select_low_i && $past(select_low_i, 4) && !$past(select_low_i, 12))
        else $error("frame verdict not tied to select rise");
    ctrl_hold_a: assert property ($changed({overvoltage_shutdown_enable_o, underload_shutdown_enable_o,
        overcurrent_shutdown_enable_o}) |-> frame_accept_o || !quiet)
        else $error("shutdown enables changed without accepted frame");
    drive_rise_a: assert property ((drive_o & ~$past(drive_o)) != 12'h000 |-> $past(frame_accept_o) || !quiet)
        else $error("driver turned on without command");
    sleep_clear_a: assert property (!enable_i [*8] |->
        drive_o == 12'h000 && !sdo_oe_o && !overcurrent_shutdown_enable_o)
        else $error("state kept during sleep");
    reject_keep_a: assert property (frame_reject_o && quiet |=> $stable(drive_o) [*3])
        else $error("rejected frame changed drivers");
endmodule
bind half_bridge_spi_port half_bridge_spi_checker chk (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(enable_i),
    .select_low_i(select_low_i),
    .overvoltage_i(overvoltage_i),
    .undervoltage_lockout_i(undervoltage_lockout_i),
    .over_temp_i(over_temp_i),
    .underload_i(underload_i),
    .overcurrent_i(overcurrent_i),
    .sdo_oe_o(sdo_oe_o),
    .drive_o(drive_o),
    .overvoltage_shutdown_enable_o(overvoltage_shutdown_enable_o),
    .underload_shutdown_enable_o(underload_shutdown_enable_o),
    .overcurrent_shutdown_enable_o(overcurrent_shutdown_enable_o),
    .frame_accept_o(frame_accept_o),
    .frame_reject_o(frame_reject_o)
);
`default_nettype wire

// ==== spi_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Serial master; clock idles low, idle pins at their pull levels
module spi_master_model (
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    output logic select_low_o,
    output logic sclk_o,
    output logic sdi_o
);
    int gap_ns = 300;
    initial
    begin
        select_low_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end
    // ============================================================
    // One frame of n bits; bits read while not enabled are unknown
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        select_low_o = 1'b0;
        #100;
        for (int i = 0; i < n; i++)
        begin
            sdi_o = tx[i];
            sclk_o = 1'b1;
            #62.5;
            rx[i] = sdo_oe_i ? sdo_i : 1'bx;
            sclk_o = 1'b0;
            #62.5;
        end
        #100;
        select_low_o = 1'b1;
        sdi_o = 1'b0;
        #gap_ns;
    endtask
endmodule
`default_nettype wire

// ==== test_half_bridge_spi_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_half_bridge_spi_port;
    import half_bridge_pkg::*;
    logic core_clk_i;
    logic sys_rst_i;
    logic enable_i;
    logic [FAULT_BITS-1:0] flt;
    wire select_low;
    wire sclk;
    wire sdi;
    logic sdo;
    logic sdo_oe;
    logic [DRV_COUNT-1:0] drive;
    logic ov_en;
    logic ul_en;
    logic oc_en;
    logic acc;
    logic rej;
    logic gap_short;
    logic [31:0] rx;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_acc = 0;
    int n_rej = 0;
    half_bridge_spi_port uut (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .enable_i(enable_i),
        .select_low_i(select_low),
        .sclk_i(sclk),
        .sdi_i(sdi),
        .overvoltage_i(flt[FLT_OV]),
        .undervoltage_lockout_i(flt[FLT_UV]),
        .over_temp_i(flt[FLT_OT]),
        .thermal_warning_i(flt[FLT_TW]),
        .underload_i(flt[FLT_UL_LSB +: DRV_COUNT]),
        .overcurrent_i(flt[FLT_OC_LSB +: DRV_COUNT]),
        .sdo_o(sdo),
        .sdo_oe_o(sdo_oe),
        .drive_o(drive),
        .overvoltage_shutdown_enable_o(ov_en),
        .underload_shutdown_enable_o(ul_en),
        .overcurrent_shutdown_enable_o(oc_en),
        .frame_accept_o(acc),
        .frame_reject_o(rej),
        .select_gap_short_o(gap_short)
    );
    spi_master_model m (
        .sdo_i(sdo),
        .sdo_oe_i(sdo_oe),
        .select_low_o(select_low),
        .sclk_o(sclk),
        .sdi_o(sdi)
    );
    initial
    begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
    begin
        if (acc === 1'b1) n_acc++;
        if (rej === 1'b1) n_rej++;
    end
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic pulse(input logic [FAULT_BITS-1:0] v);
        @(posedge core_clk_i);
        #1 flt = v;
        repeat (10) @(posedge core_clk_i);
        #1 flt = FAULT_RESET;
        repeat (10) @(posedge core_clk_i);
    endtask
    // ============================================================
    // Scenarios
    task automatic t_cmd;
        logic [15:0] cmds [4];
        logic [15:0] prev;
        int a;
        cmds = '{16'ha556, 16'h4aa8, 16'h3ffe, 16'h8006};
        prev = 16'h0000;
        check("reset drive", {ov_en, ul_en, oc_en, sdo_oe, drive}, 32'h0);
        foreach (cmds[k])
        begin
            a = n_acc;
            m.xfer({16'h0000, cmds[k]}, 16, rx);
            check("status", rx[15:0], prev & 16'h1ffe);
            check("accepts", n_acc, a + 1);
            check("drive", drive, cmds[k][12:1]);
            check("enables", {ov_en, ul_en, oc_en}, cmds[k][15:13]);
            prev = cmds[k];
        end
        $display("test commands done");
    endtask
    task automatic t_reject;
        int lens [4];
        int r;
        lens = '{0, 8, 17, 31};
        foreach (lens[k])
        begin
            r = n_rej;
            m.xfer(32'hffffffff, lens[k], rx);
            check("rejects", n_rej, r + 1);
            check("drive kept", drive, 12'h003);
            check("enables kept", {ov_en, ul_en, oc_en}, 3'b100);
        end
        m.xfer(32'h2018c3c3, 32, rx);
        check("chain out", rx, 32'hc3c30006);
        check("chain drive", drive, 12'h00c);
        $display("test framing done");
    endtask
    task automatic t_fault;
        logic [FAULT_BITS-1:0] vec [5];
        logic [15:0] st [5];
        vec = '{28'h0000008, 28'h0000001, 28'h0000002, 28'h0000040, 28'h0080000};
        st = '{16'h0019, 16'h8018, 16'h8018, 16'h4018, 16'h2008};
        foreach (vec[k])
        begin
            pulse(vec[k]);
            check("fault drive", drive, k == 4 ? 12'h004 : 12'h00c);
            m.xfer(32'h00002019, 16, rx);
            check("flagged", rx[15:0], st[k]);
            m.xfer(32'h00002018, 16, rx);
            check("cleared", rx[15:0], 16'h0018);
        end
        $display("test faults done");
    endtask
    task automatic t_sleep;
        pulse(28'h0000008);
        #1 enable_i = 1'b0;
        repeat (10) @(posedge core_clk_i);
        #1 enable_i = 1'b1;
        repeat (10) @(posedge core_clk_i);
        check("sleep state", {ov_en, ul_en, oc_en, drive}, 32'h0);
        m.xfer(32'h0, 16, rx);
        check("sleep status", rx[15:0], 16'h0000);
        m.xfer(32'h00000006, 16, rx);
        check("woken drive", drive, 12'h003);
        @(posedge core_clk_i);
        #1 sys_rst_i = 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (8) @(posedge core_clk_i);
        #1 check("rerun drive", {ov_en, ul_en, oc_en, sdo_oe, drive}, 32'h0);
        $display("test sleep done");
    endtask
    task automatic t_off;
        m.xfer(32'h0000e018, 16, rx);
        @(posedge core_clk_i);
        #1 flt = 28'h0000001;
        repeat (10) @(posedge core_clk_i);
        #1 check("ov off", drive, 12'h000);
        flt = 28'h0000040;
        repeat (10) @(posedge core_clk_i);
        #1 check("ul off", drive, 12'h008);
        flt = FAULT_RESET;
        repeat (10) @(posedge core_clk_i);
        check("ul latched", drive, 12'h008);
        m.xfer(32'h0000e019, 16, rx);
        check("off status", rx[15:0], 16'hc010);
        check("off cleared", drive, 12'h00c);
        $display("test shutdown done");
    endtask
    task automatic t_gap;
        m.gap_ns = 100;
        m.xfer(32'h0000001e, 16, rx);
        m.gap_ns = 300;
        m.xfer(32'h0000001e, 16, rx);
        check("gap short", gap_short, 1'b1);
        m.xfer(32'h0000001e, 16, rx);
        check("gap long", gap_short, 1'b0);
        check("gap drive", drive, 12'h00f);
        $display("test gap done");
    endtask
    initial
    begin
        sys_rst_i = 1'b1;
        enable_i = 1'b1;
        flt = FAULT_RESET;
        repeat (2) @(posedge core_clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (8) @(posedge core_clk_i);
        t_cmd;
        t_reject;
        t_fault;
        t_off;
        t_gap;
        t_sleep;
        stop_test;
    end
    initial
    begin
        #500000;
        n_mismatch++;
        stop_test;
    end
endmodule
`default_nettype wire
